// ===== logic/fsm_top.sv
// Top of the framer-side rail mode selection for eight channels.
// Assumes framer pins arrive asynchronously to clock_i and line-side signals come from
// the device's own decoders on clock_i; transmit data is handed on to the line encoders.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// [RULE1] Each channel's select governs both its receive and transmit framer pins with no other setup.
// [RULE2] A low select keeps the channel in two-rail mode with separate plus and minus data.
// [RULE3] Unipolar mode is entered only after the select has been high for more than 16 master clocks.
// [RULE4] In unipolar mode the receive minus pin carries the bipolar violation flag.
// [RULE5] The transmit minus pin doubles as the select and is held high by the framer for unipolar mode.
// [RULE6] In unipolar mode the plus pins carry single-rail data and the clock pins are unchanged.
module fsm_top #(
   parameter int CH = fsm_pkg::CHANNELS,
   parameter int HOLD = fsm_pkg::UNI_HOLD_CYCLES
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic [CH-1:0] tx_plus_rail_i,
   input wire logic [CH-1:0] tx_minus_rail_i,
   input wire logic [CH-1:0] tx_input_clock_i,
   input wire logic [CH-1:0] line_rx_plus_i,
   input wire logic [CH-1:0] line_rx_minus_i,
   input wire logic [CH-1:0] line_violation_i,
   input wire logic [CH-1:0] line_rx_clock_i,
   output logic [CH-1:0] rx_plus_rail_o,
   output logic [CH-1:0] rx_minus_rail_o,
   output logic [CH-1:0] rx_clock_o,
   output logic [CH-1:0] enc_tx_plus_o,
   output logic [CH-1:0] enc_tx_minus_o,
   output logic [CH-1:0] enc_tx_clock_o,
   output logic [CH-1:0] unipolar_o
);
   initial begin
      if (CH < 1) $error("fsm_top: CH must be positive");
   end

   // Two-stage synchronisers for every framer pin; the first stage feeds only the second.
   logic [CH-1:0] tpl_m_r, tpl_s_r, tmi_m_r, tmi_s_r, tck_m_r, tck_s_r;
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         {tpl_m_r, tpl_s_r, tmi_m_r, tmi_s_r, tck_m_r, tck_s_r} <= '0;
      end else begin
         tpl_m_r <= tx_plus_rail_i;
         tpl_s_r <= tpl_m_r;
         tmi_m_r <= tx_minus_rail_i;
         tmi_s_r <= tmi_m_r;
         tck_m_r <= tx_input_clock_i;
         tck_s_r <= tck_m_r;
      end
   end

   wire [CH-1:0] rxp_nxt, rxm_nxt, txp_nxt, txm_nxt, uni_nxt;

   // One qualifier and steering path per channel.
   for (genvar c = 0; c < CH; c++) begin : g_ch
      fsm_chan #(.HOLD(HOLD)) u_chan (
         .clock_i(clock_i),
         .sys_rst_i(sys_rst_i),
         .tx_minus_s_i(tmi_s_r[c]),
         .tx_plus_s_i(tpl_s_r[c]),
         .rx_plus_d_i(line_rx_plus_i[c]),
         .rx_minus_d_i(line_rx_minus_i[c]),
         .violation_d_i(line_violation_i[c]),
         .unipolar_o(uni_nxt[c]),
         .rx_plus_nxt_o(rxp_nxt[c]),
         .rx_minus_nxt_o(rxm_nxt[c]),
         .tx_plus_nxt_o(txp_nxt[c]),
         .tx_minus_nxt_o(txm_nxt[c])
      );
   end

   // Output registers; clocks pass unchanged in both modes, delayed like the data.
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         {rx_plus_rail_o, rx_minus_rail_o, rx_clock_o} <= '0;
         {enc_tx_plus_o, enc_tx_minus_o, enc_tx_clock_o, unipolar_o} <= '0;
      end else begin
         rx_plus_rail_o <= rxp_nxt; // RULE6
         rx_minus_rail_o <= rxm_nxt; // RULE4
         rx_clock_o <= line_rx_clock_i; // RULE6
         enc_tx_plus_o <= txp_nxt; // RULE6
         enc_tx_minus_o <= txm_nxt; // RULE5
         enc_tx_clock_o <= tck_s_r; // RULE6
         unipolar_o <= uni_nxt; // RULE1
      end
   end

   // The violation flag reaches the minus pin one edge after it is presented in unipolar mode.
   // The release edge is skipped: the output flops still load reset values there.
   flag_route_a : assert property (@(posedge clock_i) disable iff (sys_rst_i)
      uni_nxt[0] && !$past(sys_rst_i) |=> rx_minus_rail_o[0] == $past(line_violation_i[0])) // RULE4
      else $error("violation flag not routed");
   // Transmit minus data is never passed on while unipolar.
   tx_minus_quiet_a : assert property (@(posedge clock_i) disable iff (sys_rst_i)
      unipolar_o[0] |-> !enc_tx_minus_o[0]) // RULE5
      else $error("minus rail leaked in unipolar mode");
   // Bipolar receive minus follows line data.
   rx_minus_bip_a : assert property (@(posedge clock_i) disable iff (sys_rst_i)
      !uni_nxt[0] && !$past(sys_rst_i) |=> rx_minus_rail_o[0] == $past(line_rx_minus_i[0])) // RULE2
      else $error("bipolar minus data not routed");
   // Plus receive data passes in either mode.
   rx_plus_pass_a : assert property (@(posedge clock_i) disable iff (sys_rst_i)
      !$past(sys_rst_i) |=> rx_plus_rail_o[0] == $past(line_rx_plus_i[0])) // RULE6
      else $error("plus data not routed");
   // The mode pin shows the qualified mode one edge later, for every channel.
   mode_out_a : assert property (@(posedge clock_i) disable iff (sys_rst_i)
      !$past(sys_rst_i) |=> unipolar_o == $past(uni_nxt)) // RULE1
      else $error("mode output does not follow qualifier");
endmodule : fsm_top
`default_nettype wire

// ===== logic/fsm_pkg.sv
// Package for the framer-side rail mode selection block.
// Assumes a single 10 MHz master clock and no software registers.
package fsm_pkg;
   localparam int CHANNELS = 8;
   // Select must stay high for more than this many consecutive master clock cycles.
   localparam int UNI_HOLD_CYCLES = 16;
   localparam int CNT_W = 5;
   localparam logic RESET_MODE_UNI = 1'b0;
   localparam logic [1:0] RESET_LINK_SYNC = 2'h0;
endpackage : fsm_pkg

// ===== logic/fsm_chan.sv
// One channel of rail mode selection: select qualification and pin steering.
// Assumes every input has already been brought into the clock_i domain.
`timescale 1ns/100ps
`default_nettype none
module fsm_chan #(
   parameter int HOLD = fsm_pkg::UNI_HOLD_CYCLES
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic tx_minus_s_i,
   input wire logic tx_plus_s_i,
   input wire logic rx_plus_d_i,
   input wire logic rx_minus_d_i,
   input wire logic violation_d_i,
   output logic unipolar_o,
   output logic rx_plus_nxt_o,
   output logic rx_minus_nxt_o,
   output logic tx_plus_nxt_o,
   output logic tx_minus_nxt_o
);
   logic [fsm_pkg::CNT_W-1:0] high_cnt_r;
   logic unipolar_r;
   wire sat = (high_cnt_r == (fsm_pkg::CNT_W)'(HOLD));

   initial begin
      if (HOLD < 1 || HOLD >= (1 << fsm_pkg::CNT_W) - 1) $error("fsm_chan: HOLD out of range");
   end

   // Count consecutive high samples; one low sample drops straight back to bipolar.
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         high_cnt_r <= '0;
         unipolar_r <= fsm_pkg::RESET_MODE_UNI;
      end else if (!tx_minus_s_i) begin
         high_cnt_r <= '0; // RULE2
         unipolar_r <= 1'b0; // RULE2
      end else if (sat) begin
         unipolar_r <= 1'b1; // RULE3
      end else begin
         high_cnt_r <= high_cnt_r + 1'b1;
      end
   end

   // Steering: in unipolar mode the receive minus rail carries the violation flag and the transmit minus rail is held low.
   assign unipolar_o = unipolar_r; // RULE1
   assign rx_plus_nxt_o = rx_plus_d_i; // RULE6
   assign rx_minus_nxt_o = unipolar_r ? violation_d_i : rx_minus_d_i; // RULE4
   assign tx_plus_nxt_o = tx_plus_s_i; // RULE6
   assign tx_minus_nxt_o = unipolar_r ? 1'b0 : tx_minus_s_i; // RULE5

   // Unipolar is entered only after more than HOLD consecutive high samples.
   unipolar_entry_a : assert property (@(posedge clock_i) disable iff (sys_rst_i)
      $rose(unipolar_r) |-> $past(high_cnt_r) == (fsm_pkg::CNT_W)'(HOLD)) // RULE3
      else $error("unipolar entered without full hold");
   // A low select leaves unipolar on the next edge.
   bipolar_drop_a : assert property (@(posedge clock_i) disable iff (sys_rst_i)
      !tx_minus_s_i |=> !unipolar_r) // RULE2
      else $error("bipolar not restored after low select");
endmodule : fsm_chan
`default_nettype wire

// ===== bench/fsm_framer.sv
// Framer model driving the transmit rails and clocks of eight channels.
// Assumes the bench sets mode requests and data at clock_i edges.
`timescale 1ns/100ps
`default_nettype none
module fsm_framer (
   input wire logic run_i,
   input wire logic [7:0] uni_i,
   input wire logic [7:0] plus_i,
   input wire logic [7:0] minus_i,
   output logic [7:0] tx_plus_rail_o,
   output logic [7:0] tx_minus_rail_o,
   output var logic [7:0] tx_input_clock_o
);
   // A unipolar channel holds its minus rail high as the select.
   assign tx_minus_rail_o = uni_i | minus_i;
   assign tx_plus_rail_o = plus_i;
   // The clock stands low between frames, so a stuck sampler shows up.
   initial begin
      tx_input_clock_o = 8'h00;
      forever #400 tx_input_clock_o = run_i ? ~tx_input_clock_o : 8'h00;
   end
endmodule : fsm_framer
`default_nettype wire

// ===== bench/framer_side_io_mode_select_tb.sv
// Bench for the rail mode select block with a framer model.
// Assumes a short HOLD so qualification takes only a few cycles.
`timescale 1ns/100ps
`default_nettype none
module framer_side_io_mode_select_tb;
   localparam int HOLD = 3;
   logic clock_i = 1'b0, sys_rst_i = 1'b1, run = 1'b0;
   logic [7:0] uni = '0, plus = '0, minus = '0, lrp = '0, lrm = '0, lv = '0, lrc = '0;
   wire logic [7:0] tp, tm, tc, rp, rm, rc, ep, em, ec, up;
   int n_mismatch = 0, tests_run = 0;
   fsm_framer framer (.run_i(run), .uni_i(uni), .plus_i(plus), .minus_i(minus),
      .tx_plus_rail_o(tp), .tx_minus_rail_o(tm), .tx_input_clock_o(tc));
   fsm_top #(.CH(8), .HOLD(HOLD)) uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .tx_plus_rail_i(tp), .tx_minus_rail_i(tm), .tx_input_clock_i(tc),
      .line_rx_plus_i(lrp), .line_rx_minus_i(lrm), .line_violation_i(lv), .line_rx_clock_i(lrc),
      .rx_plus_rail_o(rp), .rx_minus_rail_o(rm), .rx_clock_o(rc), .enc_tx_plus_o(ep),
      .enc_tx_minus_o(em), .enc_tx_clock_o(ec), .unipolar_o(up));
   initial forever #50 clock_i = ~clock_i;
   task automatic summarize;
      if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : cyc
   // Two-rail pass-through; minus data is dropped before it could qualify.
   task automatic t_bipolar;
      @(posedge clock_i);
      {lrp, lrm, lv, lrc, plus, minus} <= {8'ha5, 8'h5a, 8'hff, 8'h3c, 8'hc3, 8'h96};
      cyc(3);
      chk(rp, 8'ha5);
      chk(rm, 8'h5a);
      chk(rc, 8'h3c);
      chk(em, 8'h96);
      chk(ep, 8'hc3);
      minus <= 8'h00;
      cyc(4);
      chk(up, 8'h00);
   endtask : t_bipolar
   // A select pulse of HOLD samples must be refused.
   task automatic t_short;
      @(posedge clock_i);
      uni <= 8'hff;
      repeat (HOLD) @(posedge clock_i);
      uni <= 8'h00;
      cyc(8);
      chk(up, 8'h00);
   endtask : t_short
   // Half the channels go unipolar; the others must stay two-rail.
   task automatic t_uni;
      int i;
      int k;
      @(posedge clock_i);
      {uni, lv, lrm, plus} <= {8'h0f, 8'h05, 8'ha0, 8'h5a};
      for (i = 0; i < HOLD + 8 && up !== 8'h0f; i++) cyc(1);
      chk(up, 8'h0f);
      chk(8'(i), 8'(HOLD + 4));
      chk(rm, 8'ha5);
      chk(rp, 8'ha5);
      chk(ep, 8'h5a);
      chk(em, 8'h00);
      run <= 1'b1;
      for (k = 0; k < 20 && tc[0] !== 1'b1; k++) cyc(1);
      cyc(2);
      chk(ec, tc);
      chk(ec, 8'hff);
   endtask : t_uni
   // Reset in mid-run clears the mode; a select still held high qualifies again.
   task automatic t_reset;
      @(posedge clock_i);
      uni <= 8'hf0;
      cyc(HOLD + 5);
      chk(up, 8'hf0);
      sys_rst_i <= 1'b1;
      cyc(2);
      chk(up, 8'h00);
      chk(rm, 8'h00);
      chk(ec, 8'h00);
      sys_rst_i <= 1'b0;
      cyc(HOLD + 5);
      chk(up, 8'hf0);
   endtask : t_reset
   // A low select returns the channels to two-rail mode.
   task automatic t_back;
      @(posedge clock_i);
      uni <= 8'h00;
      cyc(5);
      chk(up, 8'h00);
      chk(rm, 8'ha0);
   endtask : t_back
   initial begin
      repeat (16) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      cyc(2);
      t_bipolar();
      t_short();
      t_uni();
      t_back();
      t_reset();
      summarize();
   end
   // Watchdog for the waits on the framer clock.
   initial begin
      #1000000;
      n_mismatch++;
      summarize();
   end
endmodule : framer_side_io_mode_select_tb
`default_nettype wire
